// [rtl/bcg_top.v]
// Brushless motor commutation gate: gate control register, dead-time
// subcounter and dead-time offset, and the six gated inverter outputs.
// Assumes PWM waveforms, mode flags and active levels come from the timer
// core on the same clock, and that the bus master holds one access per
// cycle on a 16-bit register port.
//
// Summary of operation
// - Gate control 8-bit, only in PWM modes
// - Bit 7 reads one, software writes one
// - Enable bit 6 turns gating on
// - Bit 5 picks low-side level or PWM
// - Bit 4 picks high-side level or PWM
// - Bit 3 picks capture or software commutation
// - Phase bits count only under software select
// - Codes 000..011 map per table, 111 off
// - Codes 100..110 map per table
// - Subcounter 16-bit, read-only, complementary only
// - Offset register 16-bit, complementary mode only
// - Restart in complementary mode loads offset into channel-3 counter
// - Offset register resets to all ones
`timescale 1ns/10ps
`include "bcg_regs.vh"

module bcg_top (
  input  wire                  clk_in,
  input  wire                  rstn_in,
  input  wire [`BCG_IDX_W-1:0] reg_index_in,
  input  wire                  reg_write_in,
  input  wire                  reg_read_in,
  input  wire                  reg_word_in,
  input  wire                  reg_upper_byte_in,
  input  wire [15:0]           reg_wdata_in,
  output reg  [15:0]           reg_rdata_out,
  output reg                   reg_refused_out,
  input  wire                  mode_reset_sync_in,
  input  wire                  mode_complementary_in,
  input  wire                  subcounter_run_in,
  input  wire                  counters_restart_in,
  input  wire                  capture_a_in,
  input  wire                  capture_b_in,
  input  wire                  capture_c_in,
  input  wire [2:0]            pwm_high_in,
  input  wire [2:0]            pwm_low_in,
  input  wire                  high_active_level_in,
  input  wire                  low_active_level_in,
  output reg                   u_high_pin_out,
  output reg                   v_high_pin_out,
  output reg                   w_high_pin_out,
  output reg                   u_low_pin_out,
  output reg                   v_low_pin_out,
  output reg                   w_low_pin_out,
  output reg                   channel3_load_out,
  output reg  [15:0]           channel3_load_value_out
);

  // ==========================================================
  // Reset release
  reg rst_sync_a;
  reg rst_sync_n;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_a <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_sync_a <= 1'b1;
      rst_sync_n <= rst_sync_a;
    end
  end

  // ==========================================================
  // Register state
  reg  [6:0]  motor_gate_control;
  reg  [15:0] dead_time_subcounter;
  reg  [15:0] dead_time_offset;

  wire        pwm_mode_active;
  wire        wr_gate;
  wire        wr_offset;
  wire        byte_refused;
  wire [7:0]  gate_byte;
  wire [7:0]  gate_read;

  assign pwm_mode_active = mode_reset_sync_in | mode_complementary_in;
  assign wr_gate   = reg_write_in & (reg_index_in == `BCG_IDX_GATE_CTRL);
  assign wr_offset = reg_write_in & reg_word_in & (reg_index_in == `BCG_IDX_DT_OFFSET);
  assign byte_refused = (reg_write_in | reg_read_in) & ~reg_word_in &
                        ((reg_index_in == `BCG_IDX_SUBCOUNTER) |
                         (reg_index_in == `BCG_IDX_DT_OFFSET));
  // Byte writes to the 8-bit register may use either lane
  assign gate_byte = (reg_word_in | ~reg_upper_byte_in) ? reg_wdata_in[7:0]
                                                         : reg_wdata_in[15:8];
  assign gate_read = {1'b1, motor_gate_control};

  // ==========================================================
  // Register writes
  always @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      motor_gate_control <= `BCG_GC_RESET;
      dead_time_offset   <= `BCG_DT_OFFSET_RESET;
    end else begin
      if (wr_gate) begin
        motor_gate_control <= gate_byte[`BCG_GC_WR_MSB:0];
      end
      if (wr_offset) begin
        dead_time_offset <= reg_wdata_in;
      end
    end
  end

  // ==========================================================
  // Dead-time subcounter
  // Held at zero outside complementary mode so a mode change starts clean.
  always @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dead_time_subcounter <= `BCG_SUBCNT_RESET;
    end else begin
      if (!mode_complementary_in || counters_restart_in) begin
        dead_time_subcounter <= `BCG_SUBCNT_RESET;
      end else if (subcounter_run_in) begin
        dead_time_subcounter <= dead_time_subcounter + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Read port
  reg [15:0] next_rdata;

  always @* begin
    next_rdata = `BCG_DATA_ZERO;
    case (reg_index_in)
      `BCG_IDX_GATE_CTRL: begin
        next_rdata = (reg_word_in | ~reg_upper_byte_in) ? {8'h00, gate_read}
                                                         : {gate_read, 8'h00};
      end
      `BCG_IDX_SUBCOUNTER: begin
        next_rdata = dead_time_subcounter;
      end
      `BCG_IDX_DT_OFFSET: begin
        next_rdata = dead_time_offset;
      end
      default: begin
        next_rdata = `BCG_DATA_ZERO;
      end
    endcase
    if (byte_refused) begin
      next_rdata = `BCG_DATA_ZERO;
    end
  end

  always @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_out   <= `BCG_DATA_ZERO;
      reg_refused_out <= 1'b0;
    end else begin
      if (reg_read_in) begin
        reg_rdata_out <= next_rdata;
      end
      reg_refused_out <= byte_refused;
    end
  end

  // ==========================================================
  // Commutation source and decode
  wire [2:0] phase_code;
  wire [2:0] high_on;
  wire [2:0] low_on;

  assign phase_code = motor_gate_control[`BCG_GC_SW_COMMUTE] ?
                      motor_gate_control[`BCG_GC_W_SWITCH:`BCG_GC_U_SWITCH] :
                      {capture_c_in, capture_b_in, capture_a_in};

  bcg_phase_decode u_decode (
    .code_in     (phase_code),
    .high_on_out (high_on),
    .low_on_out  (low_on)
  );

  // ==========================================================
  // Output gating
  wire       gating_on;
  wire [2:0] next_high;
  wire [2:0] next_low;

  assign gating_on = pwm_mode_active & motor_gate_control[`BCG_GC_ENABLE];

  genvar leg;
  generate
    for (leg = 0; leg < 3; leg = leg + 1) begin : gen_leg
      assign next_high[leg] = ~gating_on    ? pwm_high_in[leg] :
                              ~high_on[leg] ? ~high_active_level_in :
                              motor_gate_control[`BCG_GC_HIGH_WAVE] ? pwm_high_in[leg] :
                              high_active_level_in;
      assign next_low[leg]  = ~gating_on   ? pwm_low_in[leg] :
                              ~low_on[leg] ? ~low_active_level_in :
                              motor_gate_control[`BCG_GC_LOW_WAVE] ? pwm_low_in[leg] :
                              low_active_level_in;
    end
  endgenerate

  // Registered pins cost one cycle of latency but keep glitches off the gates
  always @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      u_high_pin_out <= 1'b0;
      v_high_pin_out <= 1'b0;
      w_high_pin_out <= 1'b0;
      u_low_pin_out  <= 1'b0;
      v_low_pin_out  <= 1'b0;
      w_low_pin_out  <= 1'b0;
    end else begin
      u_high_pin_out <= next_high[0];
      v_high_pin_out <= next_high[1];
      w_high_pin_out <= next_high[2];
      u_low_pin_out  <= next_low[0];
      v_low_pin_out  <= next_low[1];
      w_low_pin_out  <= next_low[2];
    end
  end

  // ==========================================================
  // Channel-3 preload on restart
  always @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      channel3_load_out       <= 1'b0;
      channel3_load_value_out <= `BCG_DT_OFFSET_RESET;
    end else begin
      channel3_load_out       <= counters_restart_in & mode_complementary_in;
      channel3_load_value_out <= dead_time_offset;
    end
  end

endmodule

// [rtl/bcg_regs.vh]
// Register map, field positions and reset values of the commutation gate.
// Assumes a 16-bit register port addressed by a two-bit register index.
`ifndef BCG_REGS_VH
`define BCG_REGS_VH

// ==========================================================
// Register indices
`define BCG_IDX_W            2
`define BCG_IDX_GATE_CTRL    2'h0
`define BCG_IDX_SUBCOUNTER   2'h1
`define BCG_IDX_DT_OFFSET    2'h2

// ==========================================================
// Gate control fields
`define BCG_GC_RESERVED      7
`define BCG_GC_ENABLE        6
`define BCG_GC_LOW_WAVE      5
`define BCG_GC_HIGH_WAVE     4
`define BCG_GC_SW_COMMUTE    3
`define BCG_GC_W_SWITCH      2
`define BCG_GC_V_SWITCH      1
`define BCG_GC_U_SWITCH      0
`define BCG_GC_WR_MSB        6

// ==========================================================
// Reset values
`define BCG_GC_RESET         7'h00
`define BCG_SUBCNT_RESET     16'h0000
`define BCG_DT_OFFSET_RESET  16'hffff
`define BCG_DATA_ZERO        16'h0000

`endif

// [rtl/bcg_phase_decode.v]
// Phase code decoder: three-bit (w,v,u) code to six pin on-states.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps

module bcg_phase_decode (
  input  wire [2:0] code_in,
  output reg  [2:0] high_on_out,
  output reg  [2:0] low_on_out
);

  // ==========================================================
  // Decode table, bit order u=0, v=1, w=2
  always @* begin
    high_on_out = 3'h0;
    low_on_out  = 3'h0;
    case (code_in)
      3'h0: begin
        high_on_out = 3'h0;
        low_on_out  = 3'h0;
      end
      3'h1: begin
        high_on_out = 3'h1;
        low_on_out  = 3'h4;
      end
      3'h2: begin
        high_on_out = 3'h2;
        low_on_out  = 3'h1;
      end
      3'h3: begin
        high_on_out = 3'h2;
        low_on_out  = 3'h4;
      end
      3'h4: begin
        high_on_out = 3'h4;
        low_on_out  = 3'h2;
      end
      3'h5: begin
        high_on_out = 3'h1;
        low_on_out  = 3'h2;
      end
      3'h6: begin
        high_on_out = 3'h4;
        low_on_out  = 3'h1;
      end
      default: begin
        high_on_out = 3'h0;
        low_on_out  = 3'h0;
      end
    endcase
  end

endmodule

// [bench/bcg_props.sv]
// Checker for the gate block register port and the restart load.
// Assumes it is bound to bcg_top and sees only its ports.
`timescale 1ns/10ps
module bcg_props (
  input wire        clk_in,
  input wire        rstn_in,
  input wire [1:0]  reg_index_in,
  input wire        reg_write_in,
  input wire        reg_read_in,
  input wire        reg_word_in,
  input wire [15:0] reg_wdata_in,
  input wire [15:0] reg_rdata_out,
  input wire        reg_refused_out,
  input wire        mode_complementary_in,
  input wire        counters_restart_in,
  input wire        channel3_load_out,
  input wire [15:0] channel3_load_value_out
);
  // ====
  // Helpers
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire wide = (reg_index_in == 2'h1) | (reg_index_in == 2'h2);
  wire bad  = (reg_write_in | reg_read_in) & !reg_word_in & wide;
  wire owr  = reg_write_in & reg_word_in & (reg_index_in == 2'h2);
  wire grd  = reg_read_in & reg_word_in & (reg_index_in == 2'h0);
  wire load = counters_restart_in & mode_complementary_in;
  // ====
  // Assertions
  a_refuse_byte: assert property (bad |=> reg_refused_out)
    else $error("byte access not refused");
  a_refuse_only: assert property (!bad |=> !reg_refused_out)
    else $error("spurious refusal");
  a_byte_zero: assert property (bad && reg_read_in |=> reg_rdata_out == 16'h0000)
    else $error("refused read not zero");
  a_gate_top: assert property (grd |=> reg_rdata_out[15:7] == 9'h001)
    else $error("gate control top bits wrong");
  a_rdata_hold: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  a_load_pulse: assert property (load |=> channel3_load_out)
    else $error("no channel 3 load");
  a_no_load: assert property (!load |=> !channel3_load_out)
    else $error("spurious channel 3 load");
  a_load_value: assert property (owr ##1 !owr |=>
    channel3_load_value_out == $past(reg_wdata_in, 2)) else $error("load value stale");
  c_load: cover property (load);
  c_bad: cover property (bad);
  c_owr: cover property (owr ##1 !owr);
endmodule
bind bcg_top bcg_props u_props (
  .clk_in(clk_in), .rstn_in(rstn_in), .reg_index_in(reg_index_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_word_in(reg_word_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_refused_out(reg_refused_out), .mode_complementary_in(mode_complementary_in),
  .counters_restart_in(counters_restart_in), .channel3_load_out(channel3_load_out),
  .channel3_load_value_out(channel3_load_value_out));

// [bench/bcg_inverter.sv]
// Inverter gate-drive model: flags a leg whose two switches are both on.
// Assumes the active levels given to the gate block.
`timescale 1ns/10ps
module bcg_inverter (
  input  wire [2:0] high_in,
  input  wire [2:0] low_in,
  input  wire       high_act_in,
  input  wire       low_act_in,
  output wire       short_out
);
  // ====
  // Shoot-through, which would wreck a real bridge leg
  assign short_out = |((high_in ~^ {3{high_act_in}}) & (low_in ~^ {3{low_act_in}}));
endmodule

// [bench/testbench.sv]
// Self-checking bench for the commutation gate block.
// Assumes bcg_top with its bound checker and the inverter model.
`timescale 1ns/10ps
module testbench;
  reg         clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, word = 1'b1, up = 1'b0;
  reg         msync = 1'b0, mcomp = 1'b0, run = 1'b0, rst = 1'b0, ha = 1'b1, la = 1'b1;
  reg  [1:0]  idx = 2'h0;
  reg  [2:0]  cap = 3'h0, ph = 3'h0, pl = 3'h0;
  reg  [15:0] wd = 16'h0000;
  wire [15:0] rdat, ldv;
  wire [5:0]  pin;
  wire        refu, ld, short;
  integer     fails = 0, cmp_count = 0, c;
  always #10 clk = ~clk;
  bcg_top dut (
    .clk_in(clk), .rstn_in(rstn), .reg_index_in(idx), .reg_write_in(wr),
    .reg_read_in(rd), .reg_word_in(word), .reg_upper_byte_in(up), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .reg_refused_out(refu), .mode_reset_sync_in(msync),
    .mode_complementary_in(mcomp), .subcounter_run_in(run), .counters_restart_in(rst),
    .capture_a_in(cap[0]), .capture_b_in(cap[1]), .capture_c_in(cap[2]),
    .pwm_high_in(ph), .pwm_low_in(pl), .high_active_level_in(ha),
    .low_active_level_in(la), .u_high_pin_out(pin[3]), .v_high_pin_out(pin[4]),
    .w_high_pin_out(pin[5]), .u_low_pin_out(pin[0]), .v_low_pin_out(pin[1]),
    .w_low_pin_out(pin[2]), .channel3_load_out(ld), .channel3_load_value_out(ldv));
  bcg_inverter u_inv (.high_in(pin[5:3]), .low_in(pin[2:0]), .high_act_in(ha),
    .low_act_in(la), .short_out(short));
  // ====
  // Shared tasks
  function [5:0] tbl(input [2:0] k);
    case (k)
      3'h1: tbl = 6'h0c;
      3'h2: tbl = 6'h11;
      3'h3: tbl = 6'h14;
      3'h4: tbl = 6'h22;
      3'h5: tbl = 6'h0a;
      3'h6: tbl = 6'h21;
      default: tbl = 6'h00;
    endcase
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task bus(input [1:0] i, input w, input b, input u, input [15:0] d);
    begin
      @(posedge clk);
      idx <= i; wr <= w; rd <= !w; word <= b; up <= u; wd <= d;
      @(posedge clk);
      wr <= 1'b0; rd <= 1'b0;
      #1;
    end
  endtask
  task gate(input [7:0] v);
    begin
      bus(2'h0, 1'b1, 1'b1, 1'b0, {8'h00, v});
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // ====
  // Scenarios
  task t_regs;
    begin
      bus(2'h0, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h0080);
      bus(2'h1, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h0000);
      bus(2'h2, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'hffff);
      bus(2'h2, 1'b1, 1'b1, 1'b0, 16'h1234);
      bus(2'h2, 1'b1, 1'b0, 1'b0, 16'h0055); chk({15'h0, refu}, 16'h0001);
      bus(2'h2, 1'b0, 1'b0, 1'b1, 16'h0000); chk(rdat, 16'h0000);
      bus(2'h2, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h1234);
      bus(2'h1, 1'b1, 1'b1, 1'b0, 16'h5555);
      bus(2'h1, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h0000);
      bus(2'h0, 1'b1, 1'b1, 1'b0, 16'h00ff);
      bus(2'h0, 1'b0, 1'b0, 1'b1, 16'h0000); chk(rdat, 16'hff00);
      gate(8'h80); bus(2'h0, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h0080);
    end
  endtask
  task t_gating;
    begin
      // output master enables assumed set before modes
      @(posedge clk); msync <= 1'b1;
      for (c = 0; c < 8; c = c + 1) begin
        gate(8'hc8 | c[7:0]); chk({10'h0, pin}, {10'h0, tbl(c[2:0])});
        chk({15'h0, short}, 16'h0000);
      end
      gate(8'hc7);
      for (c = 0; c < 8; c = c + 1) begin
        @(posedge clk); cap <= c[2:0];
        gate(8'hc7); chk({10'h0, pin}, {10'h0, tbl(c[2:0])});
      end
      gate(8'hd9); chk({10'h0, pin}, 16'h0004);
      gate(8'he9); chk({10'h0, pin}, 16'h0008);
      @(posedge clk); ha <= 1'b0; la <= 1'b0;
      gate(8'hc9); chk({10'h0, pin}, 16'h0033);
      @(posedge clk); ph <= 3'h5; pl <= 3'h2;
      gate(8'hd9); chk({10'h0, pin}, 16'h003b);
      gate(8'h89); chk({10'h0, pin}, 16'h002a);
      @(posedge clk); msync <= 1'b0;
      gate(8'hc9); chk({10'h0, pin}, 16'h002a);
      @(posedge clk); mcomp <= 1'b1;
      gate(8'hc9); chk({10'h0, pin}, 16'h0033);
    end
  endtask
  task t_restart;
    begin
      @(posedge clk); mcomp <= 1'b1; rst <= 1'b1;
      @(posedge clk); rst <= 1'b0; run <= 1'b1;
      #1; chk({15'h0, ld}, 16'h0001); chk(ldv, 16'h1234);
      repeat (5) @(posedge clk);
      run <= 1'b0;
      bus(2'h1, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h0005);
      bus(2'h1, 1'b1, 1'b1, 1'b0, 16'h5555);
      bus(2'h1, 1'b0, 1'b1, 1'b0, 16'h0000); chk(rdat, 16'h0005);
      bus(2'h1, 1'b0, 1'b0, 1'b0, 16'h0000); chk({15'h0, refu}, 16'h0001);
      @(posedge clk); mcomp <= 1'b0; rst <= 1'b1;
      @(posedge clk); rst <= 1'b0;
      #1; chk({15'h0, ld}, 16'h0000);
    end
  endtask
  task finish_test;
    begin
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_gating;
    t_restart;
    finish_test;
  end
endmodule
